// >>> common/psr_pkg.sv
package psr_pkg;

  // Bus widths of the memory (4M x 16 part)
  localparam int ADDR_W    = 22;
  localparam int DATA_W    = 16;
  localparam int PAGE_BITS = 4;

  // Clock period, ns
  localparam int CLK_PERIOD_NS = 8;

  // Timing figures of the -70 speed grade, ns
  localparam int WRITE_CYCLE_TIME_NS       = 70;
  localparam int WRITE_STROBE_WIDTH_NS     = 46;
  localparam int DATA_SETUP_WINDOW_NS      = 23;
  localparam int READ_ACCESS_NS            = 70;
  localparam int PAGE_ACCESS_NS            = 20;
  localparam int SELECT_HIGH_NS            = 5;
  localparam int MAX_SELECT_ACTIVE_TIME_NS = 10000;
  localparam int MAX_ADDRESS_HOLD_TIME_NS  = 10000;

  // Least times round up, longest times round down
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC_MIN  = (WRITE_STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC_MIN   = (DATA_SETUP_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Stretched strobe covers both the plain and the extended write case
  localparam int STROBE_CYC      = (WRITE_CYCLE_CYC > STROBE_CYC_MIN) ? WRITE_CYCLE_CYC : STROBE_CYC_MIN;
  localparam int READ_CYC        = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_CYC        = (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_HIGH_CYC = (SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_MAX_CYC  = MAX_SELECT_ACTIVE_TIME_NS / CLK_PERIOD_NS;
  // Margin so an access already started still ends inside the limit
  localparam int SELECT_GUARD_CYC = STROBE_CYC + READ_CYC + 4;
  localparam int SELECT_STOP_CYC  = SELECT_MAX_CYC - SELECT_GUARD_CYC;

  localparam int CNT_W   = 4;
  localparam int TIMER_W = 11;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WRITE = 3'b010,
    ST_WHOLD = 3'b011,
    ST_GAP   = 3'b100
  } psr_state_e;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        byte_en;
  } psr_req_s;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              lb_n;
    logic              ub_n;
    logic [ADDR_W-1:0] addr;
  } psr_pins_s;

endpackage : psr_pkg

// >>> verilog/psr_span_timer.sv
`timescale 1ns/1ps
`default_nettype none

module psr_span_timer #(
  parameter int                 WIDTH = psr_pkg::TIMER_W,
  parameter logic [WIDTH-1:0]   LIMIT = WIDTH'(psr_pkg::SELECT_STOP_CYC)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Span being timed
  input  wire logic run,
  // Span has reached the limit
  output logic      expired
);

  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_reg <= '0;
    else if (!run)
      count_reg <= '0;
    else if (count_reg != LIMIT)
      count_reg <= count_reg + WIDTH'(1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      expired <= 1'b0;
    else
      expired <= run && (count_reg >= LIMIT);
  end

endmodule : psr_span_timer

`default_nettype wire

// >>> verilog/psr_ctrl.sv
// How it works
// - Every write finishes well inside 10 us.
// - After access: drop select or change address.
// - Page mode off: select or address span short.
// - Page mode on: select drops after each write.
// - Page mode on: write lasts under 10 us.
// - Strobe and data window stretched to cycle time.
`timescale 1ns/1ps
`default_nettype none

module psr_ctrl (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Configuration
  input  wire logic              page_mode_en,
  // Request side
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire psr_pkg::psr_req_s req,
  // Answer side
  output logic                   rsp_valid,
  output logic                   rsp_write,
  output logic [psr_pkg::DATA_W-1:0] rsp_rdata,
  // Memory pins
  output psr_pkg::psr_pins_s     mem_pins,
  input  wire logic [psr_pkg::DATA_W-1:0] mem_dq_i,
  output logic [psr_pkg::DATA_W-1:0] mem_dq_o,
  output logic                   mem_dq_oe
);

  psr_pkg::psr_state_e state_reg;
  psr_pkg::psr_state_e state_next;
  psr_pkg::psr_req_s   cur_reg;
  psr_pkg::psr_req_s   launch_req;
  logic [psr_pkg::CNT_W-1:0] cnt_reg;
  logic                last_write_reg;
  logic                accept;
  logic                selected;
  logic                same_addr;
  logic                page_hit;
  logic                may_continue;
  logic                launch;
  logic                sel_expired;
  logic                cnt_done;

  function automatic logic same_page(input logic [psr_pkg::ADDR_W-1:0] a,
                                     input logic [psr_pkg::ADDR_W-1:0] b);
    same_page = a[psr_pkg::ADDR_W-1:psr_pkg::PAGE_BITS] == b[psr_pkg::ADDR_W-1:psr_pkg::PAGE_BITS];
  endfunction : same_page

  // Select span watchdog
  psr_span_timer #(
    .WIDTH (psr_pkg::TIMER_W),
    .LIMIT (psr_pkg::TIMER_W'(psr_pkg::SELECT_STOP_CYC))
  ) u_select_timer (
    .clk     (clk),
    .rst     (rst),
    .run     (selected),
    .expired (sel_expired)
  );

  assign selected  = !mem_pins.ce_n;
  assign accept    = (state_reg == psr_pkg::ST_IDLE) && req_ready && req_valid;
  assign same_addr = (req.addr == mem_pins.addr);
  assign cnt_done  = (cnt_reg == '0);

  // Keep select low into the next access only when it is safe
  always_comb
  begin
    may_continue = 1'b1;
    if (same_addr)
      may_continue = 1'b0;
    if (page_mode_en && last_write_reg)
      may_continue = 1'b0;
    if (page_mode_en && sel_expired)
      may_continue = 1'b0;
  end

  // Page access only while still selected inside the same page
  assign page_hit = page_mode_en && selected && !last_write_reg && !req.write
                    && same_page(req.addr, mem_pins.addr);

  assign launch     = (accept && (!selected || may_continue)) || (state_reg == psr_pkg::ST_GAP);
  assign launch_req = (state_reg == psr_pkg::ST_GAP) ? cur_reg : req;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      psr_pkg::ST_IDLE:
      begin
        if (accept && selected && !may_continue)
          state_next = psr_pkg::ST_GAP;
        else if (accept)
          state_next = req.write ? psr_pkg::ST_WRITE : psr_pkg::ST_READ;
      end
      psr_pkg::ST_GAP:
        state_next = cur_reg.write ? psr_pkg::ST_WRITE : psr_pkg::ST_READ;
      psr_pkg::ST_READ:
        if (cnt_done)
          state_next = psr_pkg::ST_IDLE;
      psr_pkg::ST_WRITE:
        if (cnt_done)
          state_next = psr_pkg::ST_WHOLD;
      psr_pkg::ST_WHOLD:
        state_next = psr_pkg::ST_IDLE;
      default:
        state_next = psr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= psr_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Request handshake and capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_ready <= 1'b1;
      cur_reg   <= '0;
    end
    else
    begin
      if (accept)
      begin
        req_ready <= 1'b0;
        cur_reg   <= req;
      end
      else if (state_next == psr_pkg::ST_IDLE)
        req_ready <= 1'b1;
    end
  end

  // Access timing counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (launch && launch_req.write)
      cnt_reg <= psr_pkg::CNT_W'(psr_pkg::STROBE_CYC - 1);
    else if (launch && accept && page_hit)
      cnt_reg <= psr_pkg::CNT_W'(psr_pkg::PAGE_CYC - 1);
    else if (launch)
      cnt_reg <= psr_pkg::CNT_W'(psr_pkg::READ_CYC - 1);
    else if (!cnt_done)
      cnt_reg <= cnt_reg - psr_pkg::CNT_W'(1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      last_write_reg <= 1'b0;
    else if (launch)
      last_write_reg <= launch_req.write;
  end

  // Memory control and address pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_pins.ce_n <= 1'b1;
      mem_pins.oe_n <= 1'b1;
      mem_pins.we_n <= 1'b1;
      mem_pins.lb_n <= 1'b1;
      mem_pins.ub_n <= 1'b1;
      mem_pins.addr <= '0;
    end
    else if (launch)
    begin
      mem_pins.ce_n <= 1'b0;
      mem_pins.oe_n <= launch_req.write;
      mem_pins.we_n <= !launch_req.write;
      mem_pins.lb_n <= !launch_req.byte_en[0];
      mem_pins.ub_n <= !launch_req.byte_en[1];
      mem_pins.addr <= launch_req.addr;
    end
    else
    begin
      case (state_reg)
        psr_pkg::ST_IDLE:
          // Idle bus goes to standby unless a new access launches, which keeps select low into that access
          if (!accept)
          begin
            mem_pins.ce_n <= 1'b1;
            mem_pins.oe_n <= 1'b1;
          end
          else
          begin
            mem_pins.ce_n <= 1'b1;
            mem_pins.oe_n <= 1'b1;
          end
        psr_pkg::ST_WRITE:
          if (cnt_done)
            mem_pins.we_n <= 1'b1;
        default:
        begin
        end
      endcase
    end
  end

  // Data pins: driven for the whole strobe plus one hold cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_dq_o  <= '0;
      mem_dq_oe <= 1'b0;
    end
    else if (launch && launch_req.write)
    begin
      mem_dq_o  <= launch_req.wdata;
      mem_dq_oe <= 1'b1;
    end
    else if (state_reg == psr_pkg::ST_WHOLD || launch)
      mem_dq_oe <= 1'b0;
  end

  // Answers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_write <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (state_reg == psr_pkg::ST_READ && cnt_done)
      begin
        rsp_valid <= 1'b1;
        rsp_write <= 1'b0;
        rsp_rdata <= mem_dq_i;
      end
      else if (state_reg == psr_pkg::ST_WHOLD)
      begin
        rsp_valid <= 1'b1;
        rsp_write <= 1'b1;
      end
    end
  end

endmodule : psr_ctrl

`default_nettype wire

// >>> verification/psr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module psr_mem_model (
  // Clock
  input  wire logic                       clk,
  // Bus from the controller
  input  wire psr_pkg::psr_pins_s         pins,
  input  wire logic                       page_en,
  input  wire logic [psr_pkg::DATA_W-1:0] dq_in,
  input  wire logic                       dq_oe,
  // Data back to the controller
  output logic [psr_pkg::DATA_W-1:0]      dq_out
);
  logic [psr_pkg::DATA_W-1:0] mem [64] = '{default: 16'h0};
  logic [psr_pkg::ADDR_W-1:0] prev_addr = '0;
  logic [psr_pkg::DATA_W-1:0] last = 16'h0;
  int                         age = 0;
  int                         wcnt = 0;
  logic                       rd_ok;
  logic                       page_ok = 1'b0;
  logic [psr_pkg::ADDR_W-1:0] open_addr = '0;

  // Fresh address is never valid at once; fast reads only inside a page opened by a full read
  assign rd_ok = !pins.ce_n && !pins.oe_n && pins.we_n && pins.addr == prev_addr &&
                 (age >= psr_pkg::READ_CYC - 2 ||
                  (page_en && page_ok && age >= psr_pkg::PAGE_CYC - 2 &&
                   pins.addr[psr_pkg::ADDR_W-1:psr_pkg::PAGE_BITS] ==
                   open_addr[psr_pkg::ADDR_W-1:psr_pkg::PAGE_BITS]));
  // Unread bus toggles so stale data never looks valid
  assign dq_out = rd_ok ? mem[pins.addr[5:0]] : ~last;

  always @(posedge clk)
  begin
    last <= dq_out;
    prev_addr <= pins.addr;
    age <= (pins.ce_n || pins.addr != prev_addr) ? 0 : age + 1;
    if (pins.ce_n || !pins.we_n)
      page_ok <= 1'b0;
    else if (rd_ok)
    begin
      page_ok   <= 1'b1;
      open_addr <= pins.addr;
    end
  end

  // Short strobes are lost; array needs no refresh from outside
  always @(posedge clk)
  begin
    wcnt <= (!pins.ce_n && !pins.we_n && dq_oe) ? wcnt + 1 : 0;
    if (!pins.we_n && dq_oe && wcnt >= psr_pkg::WRITE_CYCLE_CYC - 1)
    begin
      if (!pins.lb_n)
        mem[pins.addr[5:0]][7:0] <= dq_in[7:0];
      if (!pins.ub_n)
        mem[pins.addr[5:0]][15:8] <= dq_in[15:8];
    end
  end
endmodule : psr_mem_model

`default_nettype wire

// >>> verification/psr_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

module psr_ctrl_properties (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // Request side
  input wire logic                       page_mode_en,
  input wire logic                       req_valid,
  input wire logic                       req_ready,
  input wire psr_pkg::psr_req_s          req,
  input wire logic                       rsp_valid,
  input wire logic                       rsp_write,
  // Memory pins
  input wire psr_pkg::psr_pins_s         mem_pins,
  input wire logic [psr_pkg::DATA_W-1:0] mem_dq_o,
  input wire logic                       mem_dq_oe
);
  localparam int SPAN = psr_pkg::SELECT_MAX_CYC;
  int                         sel_cnt;
  int                         adr_cnt;
  logic                       take_same;
  logic [psr_pkg::ADDR_W-1:0] prev_addr;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  assign take_same = req_valid && req_ready && !mem_pins.ce_n && (req.addr == mem_pins.addr);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sel_cnt   <= 0;
      adr_cnt   <= 0;
      prev_addr <= '0;
    end
    else
    begin
      sel_cnt   <= mem_pins.ce_n ? 0 : sel_cnt + 1;
      adr_cnt   <= (mem_pins.ce_n || mem_pins.addr != prev_addr) ? 0 : adr_cnt + 1;
      prev_addr <= mem_pins.addr;
    end
  end

  sequence strobe_held;
    (!mem_pins.we_n) [*8];
  endsequence
  sequence data_held;
    (mem_dq_oe && $stable(mem_dq_o)) [*8];
  endsequence

  chk_write_ends: assert property ($fell(mem_pins.we_n) |-> ##[1:1000] mem_pins.we_n)
    else $error("write strobe held too long");
  chk_same_addr: assert property (take_same |=> mem_pins.ce_n)
    else $error("same address continued under select");
  chk_span_either: assert property (sel_cnt < SPAN || adr_cnt < SPAN)
    else $error("select and address spans both too long");
  chk_page_wr_gap: assert property (page_mode_en && rsp_valid && rsp_write |=> mem_pins.ce_n)
    else $error("select kept after page mode write");
  chk_page_wr_len: assert property (page_mode_en && $fell(mem_pins.we_n) |-> ##[1:20] mem_pins.ce_n)
    else $error("page mode write too long");
  chk_strobe_width: assert property ($fell(mem_pins.we_n) |=> strobe_held)
    else $error("write strobe shorter than cycle time");
  chk_data_window: assert property ($fell(mem_pins.we_n) |=> data_held)
    else $error("write data window too short");
  chk_select_span: assert property (page_mode_en |-> sel_cnt < SPAN)
    else $error("select span reached limit");
endmodule : psr_ctrl_properties

bind psr_ctrl psr_ctrl_properties u_props (
  .clk(clk), .rst(rst), .page_mode_en(page_mode_en), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .rsp_valid(rsp_valid), .rsp_write(rsp_write), .mem_pins(mem_pins), .mem_dq_o(mem_dq_o),
  .mem_dq_oe(mem_dq_oe)
);

`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {logic w; logic pm; logic [21:0] a; logic [15:0] d; logic [1:0] be; logic [16:0] x;} psr_row_s;
  logic                       clk, rst, page_mode_en, req_valid, req_ready, rsp_valid, rsp_write, mem_dq_oe;
  psr_pkg::psr_req_s          req;
  psr_pkg::psr_pins_s         mem_pins;
  logic [psr_pkg::DATA_W-1:0] rsp_rdata, mem_dq_i, mem_dq_o;
  logic [16:0]                expq [$];
  int                         mismatches = 0;
  int                         n_checks = 0;
  // Same address twice, page write then read, page hit and miss; last column is the answer
  psr_row_s rows [10] = '{'{1, 0, 0, 16'hA5A5, 3, 17'h10000}, '{1, 0, 1, 16'h1234, 1, 17'h10000},
    '{1, 0, 1, 16'h5600, 2, 17'h10000}, '{0, 0, 0, 0, 3, 17'h0A5A5}, '{0, 0, 0, 0, 3, 17'h0A5A5},
    '{0, 0, 1, 0, 3, 17'h05634}, '{1, 1, 2, 16'hBEEF, 3, 17'h10000}, '{0, 1, 2, 0, 3, 17'h0BEEF},
    '{0, 1, 3, 0, 3, 17'h00000}, '{0, 1, 22'h12, 0, 3, 17'h00000}};

  psr_ctrl dut (.clk(clk), .rst(rst), .page_mode_en(page_mode_en), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_write(rsp_write), .rsp_rdata(rsp_rdata),
    .mem_pins(mem_pins), .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
  psr_mem_model u_mem (.clk(clk), .pins(mem_pins), .page_en(page_mode_en), .dq_in(mem_dq_o),
    .dq_oe(mem_dq_oe), .dq_out(mem_dq_i));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Called just after an edge; returns just after the taking edge if req_ready is already high, else one edge after the taking edge
  task automatic issue(input psr_row_s r);
    logic ok;
    page_mode_en = r.pm;
    req = '{write: r.w, addr: r.a, wdata: r.d, byte_en: r.be};
    req_valid = 1'b1;
    expq.push_back(r.x);
    ok = 1'b0;
    while (!ok)
    begin
      ok = (req_ready === 1'b1);
      @(posedge clk);
    end
    #1;
  endtask : issue

  // Extra edges let select drop before the mode may change
  task automatic drain;
    req_valid = 1'b0;
    for (int i = 0; i < 100 && expq.size() != 0; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
    check(17'(expq.size()), 17'h0);
  endtask : drain

  task automatic idle_check;
    check({11'h0, mem_pins.ce_n, mem_pins.oe_n, mem_pins.we_n, mem_dq_oe, req_ready, rsp_valid}, 17'h0003A);
  endtask : idle_check

  always @(posedge clk)
    if (rsp_valid === 1'b1)
      check({rsp_write, rsp_write ? 16'h0 : rsp_rdata}, expq.size() ? expq.pop_front() : 17'h1FFFF);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run needs about 6000 cycles
  initial
  begin
    #(20000 * 8);
    mismatches++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    page_mode_en = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (10) @(posedge clk);
    #1;
    idle_check();
    rst = 1'b0;
    foreach (rows[i])
      issue(rows[i]);
    drain();
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 400; i++)
        issue(psr_row_s'{1'b0, p[0], 22'(i % 2), 16'h0, 2'h3, (i % 2) ? 17'h05634 : 17'h0A5A5});
      drain();
    end
    issue(psr_row_s'{1'b1, 1'b1, 22'h6, 16'hC3C3, 2'h3, 17'h10000});
    req_valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b1;
    expq.delete();
    #1;
    idle_check();
    @(posedge clk);
    #1;
    rst = 1'b0;
    issue(psr_row_s'{1'b0, 1'b0, 22'h0, 16'h0, 2'h3, 17'h0A5A5});
    drain();
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
